// *** logic/cfa_pkg.sv ***
package cfa_pkg;
  // Timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int NOTIFY_PULSE_US = 100;
  localparam int NOTIFY_CYC      = NOTIFY_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int REG_TIMEOUT_MS  = 10;
  localparam int REG_TIMEOUT_DEF = REG_TIMEOUT_MS * (CLK_HZ / 1_000);
  localparam int SOFT_START_MS   = 5;
  localparam int SOFT_START_DEF  = SOFT_START_MS * (CLK_HZ / 1_000);
  localparam int CNT_W           = 20;
  localparam int PULSE_W         = 12;
  // Sizes
  localparam int NCH  = 9;
  localparam int NTHR = 12;
  localparam int NEV  = 14;
  // Converter channels
  localparam int CH_VBUS = 0;
  localparam int CH_IBUS = 1;
  localparam int CH_VOUT = 2;
  localparam int CH_VBAT = 3;
  localparam int CH_IBAT = 4;
  localparam int CH_TSBUS = 5;
  localparam int CH_TSBAT = 6;
  localparam int CH_TDIE = 7;
  localparam int CH_VAC  = 8;
  // Threshold slots
  localparam int T_DIE_TRIP = 0;
  localparam int T_TS_TRIP  = 1;
  localparam int T_DROPOUT  = 2;
  localparam int T_VBAT_REG = 3;
  localparam int T_BATTERY_CURRENT_REGULATION = 4;
  localparam int T_VBAT_ALM = 5;
  localparam int T_IBAT_OCA = 6;
  localparam int T_IBAT_UCA = 7;
  localparam int T_VBUS_ALM = 8;
  localparam int T_IBUS_ALM = 9;
  localparam int T_TDIE_ALM = 10;
  localparam int T_TS_ALM   = 11;
  // Event bits (status, flag and suppress share the layout)
  localparam int E_DIE = 0;
  localparam int E_TS  = 1;
  localparam int E_CFLY = 2;
  localparam int E_CONV = 3;
  localparam int E_VDR = 4;
  localparam int E_REGTO = 5;
  localparam int E_ALM0 = 6;
  localparam int E_SWITCHING = 13;
  // Register word indices, byte address is four times the index
  localparam logic [5:0] W_CTRL = 6'h00;
  localparam logic [5:0] W_CHEN = 6'h01;
  localparam logic [5:0] W_STAT = 6'h02;
  localparam logic [5:0] W_FLAG = 6'h03;
  localparam logic [5:0] W_MASK = 6'h04;
  localparam logic [5:0] W_THR0 = 6'h10;
  localparam int B_CHG = 0;
  localparam int B_CNV = 1;
  // Reset values
  localparam logic [8:0]  CHEN_RST    = 9'h1FF;
  localparam logic [13:0] MASK_RST    = 14'h0000;
  localparam logic [11:0] THR_RST     = 12'hFFF;
  localparam logic [11:0] THR_UCP_RST = 12'h000;
  // Two-wire target addresses, chosen by the strap
  localparam logic [6:0] TGT_ADDR_A = 7'h66;
  localparam logic [6:0] TGT_ADDR_B = 7'h65;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACKA = 7'b0000100,
    ST_WDAT = 7'b0001000,
    ST_ACKW = 7'b0010000,
    ST_RDAT = 7'b0100000,
    ST_ACKR = 7'b1000000
  } cfa_tgt_st_t;
endpackage

// *** logic/cfa_int_pulse.sv ***
`timescale 1ns/10ps
module cfa_int_pulse
  import cfa_pkg::*;
(
  input  wire logic clk_i,    // System clock
  input  wire logic rst_i,    // Synchronous reset
  input  wire logic req_i,    // Start a notify pulse
  output logic      int_o,    // Pin level while driven
  output logic      int_oe_o  // High while pin pulled low
);
  logic [PULSE_W-1:0] cnt_q;

  // Requests during a running pulse are absorbed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_oe_o <= 1'b0;
      int_o    <= 1'b0;
      cnt_q    <= '0;
    end else if (int_oe_o) begin
      if (cnt_q == PULSE_W'(NOTIFY_CYC - 1)) begin
        int_oe_o <= 1'b0;
        cnt_q    <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (req_i) begin
      int_oe_o <= 1'b1;
    end
  end
endmodule

// *** logic/cfa_i2c_tgt.sv ***
`timescale 1ns/10ps
module cfa_i2c_tgt
  import cfa_pkg::*;
(
  input  wire logic       clk_i,      // System clock
  input  wire logic       rst_i,      // Synchronous reset
  input  wire logic       scl_i,      // Serial clock pin
  input  wire logic       sda_i,      // Serial data pin
  input  wire logic [6:0] tgt_addr_i, // Own address
  input  wire logic [7:0] rd_byte_i,  // Byte at ptr_o
  output logic            sda_o,      // Data level when driven
  output logic            sda_oe_o,   // High pulls data low
  output logic [7:0]      ptr_o,      // Next byte address
  output logic [7:0]      adr_o,      // Address of last take or write
  output logic            rd_take_o,  // Byte loaded for sending
  output logic            wr_o,       // Byte written
  output logic [7:0]      wr_byte_o   // Written byte
);
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [3:0]  cnt_q;
  logic        rw_q;
  logic        first_q;
  logic        nack_q;
  cfa_tgt_st_t st_q;

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  wire eight    = (cnt_q == 4'h8);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE; sh_q <= 8'h00; tx_q <= 8'h00; cnt_q <= 4'h0;
      rw_q <= 1'b0; first_q <= 1'b0; nack_q <= 1'b0; sda_o <= 1'b0;
      sda_oe_o <= 1'b0; ptr_o <= 8'h00; adr_o <= 8'h00;
      rd_take_o <= 1'b0; wr_o <= 1'b0; wr_byte_o <= 8'h00;
    end else begin
      rd_take_o <= 1'b0;
      wr_o      <= 1'b0;
      if (start) begin
        st_q <= ST_ADDR; cnt_q <= 4'h0; sda_oe_o <= 1'b0;
      end else if (stop) begin
        st_q <= ST_IDLE; sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        sh_q   <= {sh_q[6:0], sda_q[1]};
        cnt_q  <= cnt_q + 1'b1;
        nack_q <= sda_q[1];
      end else if (scl_fall) begin
        unique case (st_q)
          ST_ADDR: if (eight) begin
            cnt_q <= 4'h0;
            rw_q  <= sh_q[0];
            if (sh_q[7:1] == tgt_addr_i) begin
              st_q <= ST_ACKA; sda_oe_o <= 1'b1;
            end else begin
              st_q <= ST_IDLE;
            end
          end
          ST_ACKA: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              st_q <= ST_RDAT; tx_q <= rd_byte_i; sda_oe_o <= ~rd_byte_i[7];
              rd_take_o <= 1'b1; adr_o <= ptr_o; ptr_o <= ptr_o + 1'b1;
            end else begin
              st_q <= ST_WDAT; sda_oe_o <= 1'b0; first_q <= 1'b1;
            end
          end
          ST_WDAT: if (eight) begin
            st_q <= ST_ACKW; sda_oe_o <= 1'b1; cnt_q <= 4'h0;
            first_q <= 1'b0;
            if (first_q) begin
              ptr_o <= sh_q;
            end else begin
              wr_o <= 1'b1; wr_byte_o <= sh_q; adr_o <= ptr_o; ptr_o <= ptr_o + 1'b1;
            end
          end
          ST_ACKW: begin
            st_q <= ST_WDAT; sda_oe_o <= 1'b0; cnt_q <= 4'h0;
          end
          ST_RDAT: if (eight) begin
            st_q <= ST_ACKR; sda_oe_o <= 1'b0; cnt_q <= 4'h0;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0}; sda_oe_o <= ~tx_q[6];
          end
          ST_ACKR: begin
            cnt_q <= 4'h0;
            if (nack_q) begin
              st_q <= ST_IDLE; sda_oe_o <= 1'b0;
            end else begin
              st_q <= ST_RDAT; tx_q <= rd_byte_i; sda_oe_o <= ~rd_byte_i[7];
              rd_take_o <= 1'b1; adr_o <= ptr_o; ptr_o <= ptr_o + 1'b1;
            end
          end
          ST_IDLE: ;
          default: begin
            st_q <= ST_IDLE; sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// *** logic/cfa_top.sv ***
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - Die overheat stops charging, clears enable
// - Thermistor ratio trip stops charging
// - Flying cap short aborts soft start
// - Short check off once switching starts
// - Converter overcurrent stops charging
// - Adapter to bus dropout trip stops charging
// - Battery voltage over limit throttles gate
// - Battery current over limit throttles gate
// - Regulation held too long stops charging
// - Alarms notify host, never stop charging
// - Seven alarms from enabled converter channels
// - Current alarms need charge enable only
// - Target address chosen by strap pin
// - Address byte carries direction, bytes eight bits
// - Target pulls data low on acknowledge
// - Multi byte reads and writes supported
// - Events pull interrupt pin low briefly
// - Event sets latch, read clears it
// - No repeat pulse until latch cleared
// - Suppress blocks pulse, latches still update
// - Trips, alarms and switching live bit raise events
// - Die and thermistor trips armed by charge or converter enable, other trips by charge enable
module cfa_top
  import cfa_pkg::*;
#(
  parameter int unsigned REG_TIMEOUT_CYC = REG_TIMEOUT_DEF, // Regulation timeout
  parameter int unsigned SOFT_START_CYC  = SOFT_START_DEF   // Soft-start length
) (
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        wb_cyc_i,     // Bus cycle
  input  wire logic        wb_stb_i,     // Bus strobe
  input  wire logic        wb_we_i,      // Bus write
  input  wire logic [7:0]  wb_adr_i,     // Byte address
  input  wire logic [3:0]  wb_sel_i,     // Byte lanes
  input  wire logic [31:0] wb_dat_i,     // Write data
  output logic [31:0]      wb_dat_o,     // Read data
  output logic             wb_ack_o,     // Acknowledge
  input  wire logic        scl_i,        // Serial clock pin
  input  wire logic        sda_i,        // Serial data pin
  output logic             sda_o,        // Serial data level
  output logic             sda_oe_o,     // Serial data pulled low
  output logic             int_o,        // Interrupt level
  output logic             int_oe_o,     // Interrupt pulled low
  input  wire logic        addr_sel_i,   // Target address strap, high picks TGT_ADDR_B
  input  wire logic        cfly_short_i, // Flying cap short comparator
  input  wire logic        conv_oc_i,    // Converter overcurrent comparator
  input  wire logic [11:0] vbus_ch_i,    // Bus voltage result
  input  wire logic [11:0] ibus_ch_i,    // Bus current result
  input  wire logic [11:0] vout_ch_i,    // Output voltage result
  input  wire logic [11:0] vbat_ch_i,    // Battery voltage result
  input  wire logic [11:0] ibat_ch_i,    // Battery current result
  input  wire logic [11:0] tsbus_ch_i,   // Connector thermistor result
  input  wire logic [11:0] tsbat_ch_i,   // Battery thermistor result
  input  wire logic [11:0] tdie_ch_i,    // Die temperature result
  input  wire logic [11:0] vac_ch_i,     // Adapter sense result
  output logic             charge_en_o,  // Charge enable
  output logic             conv_en_o,    // Converter enable
  output logic             switching_o,  // Switching live
  output logic             gate_reg_o    // Gate drive throttled
);
  logic [11:0]    ch [NCH];
  logic [11:0]    thr_q [NTHR];
  logic           chg_q, cnv_q, chg_prev_q;
  logic [8:0]     chen_q;
  logic [NEV-1:0] mask_q, flag_q, ev_prev_q;
  logic           soft_q, switching_q, gate_q;
  logic [CNT_W-1:0] sscnt_q, regcnt_q;
  logic [1:0]     strap_q, cfly_q, coc_q;
  logic [6:0]     tgt_q;
  logic           wb_ack_q;
  logic [31:0]    wb_dat_q;
  logic           i2c_wr, i2c_take;
  logic [7:0]     i2c_ptr, i2c_adr, i2c_byte;
  logic           int_oe;

  assign ch[CH_VBUS]  = vbus_ch_i;
  assign ch[CH_IBUS]  = ibus_ch_i;
  assign ch[CH_VOUT]  = vout_ch_i;
  assign ch[CH_VBAT]  = vbat_ch_i;
  assign ch[CH_IBAT]  = ibat_ch_i;
  assign ch[CH_TSBUS] = tsbus_ch_i;
  assign ch[CH_TSBAT] = tsbat_ch_i;
  assign ch[CH_TDIE]  = tdie_ch_i;
  assign ch[CH_VAC]   = vac_ch_i;

  // Ratio test ts/vout > thr/4096 without a divider
  function automatic logic ts_over(input logic [11:0] ts, input logic [11:0] vout,
                                   input logic [11:0] thr);
    ts_over = {ts, 12'h000} > (24'(thr) * 24'(vout));
  endfunction

  // True when every needed channel is enabled
  function automatic logic chan_on(input logic [8:0] need, input logic [8:0] en);
    chan_on = &(~need | en);
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= 2'h0;
      cfly_q  <= 2'h0;
      coc_q   <= 2'h0;
    end else begin
      strap_q <= {strap_q[0], addr_sel_i};
      cfly_q  <= {cfly_q[0], cfly_short_i};
      coc_q   <= {coc_q[0], conv_oc_i};
    end
  end

  // Address strap, followed after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_q <= TGT_ADDR_A;
    end else begin
      tgt_q <= strap_q[1] ? TGT_ADDR_B : TGT_ADDR_A;
    end
  end

  // Arming
  wire either = chg_q | cnv_q;
  wire [8:0] ts_need = 9'((1 << CH_TSBUS) | (1 << CH_TSBAT) | (1 << CH_VOUT));
  wire ts_ok = chan_on(ts_need, chen_q);
  wire ts_trip_hit = ts_over(ch[CH_TSBUS], ch[CH_VOUT], thr_q[T_TS_TRIP]) |
                     ts_over(ch[CH_TSBAT], ch[CH_VOUT], thr_q[T_TS_TRIP]);
  wire ts_alm_hit  = ts_over(ch[CH_TSBUS], ch[CH_VOUT], thr_q[T_TS_ALM]) |
                     ts_over(ch[CH_TSBAT], ch[CH_VOUT], thr_q[T_TS_ALM]);
  wire [11:0] drop = ch[CH_VAC] - ch[CH_VBUS];

  // Protection trips
  wire die_trip  = either & chen_q[CH_TDIE] & (ch[CH_TDIE] > thr_q[T_DIE_TRIP]);
  wire ts_trip   = either & ts_ok & ts_trip_hit;
  wire cfly_trip = chg_q & soft_q & cfly_q[1];
  wire conv_trip = chg_q & coc_q[1];
  wire vdr_trip  = chg_q & chen_q[CH_VAC] & chen_q[CH_VBUS] &
                   (ch[CH_VAC] > ch[CH_VBUS]) & (drop > thr_q[T_DROPOUT]);
  wire vreg_hit  = chen_q[CH_VBAT] & (ch[CH_VBAT] > thr_q[T_VBAT_REG]);
  wire ireg_hit  = chen_q[CH_IBAT] & (ch[CH_IBAT] > thr_q[T_BATTERY_CURRENT_REGULATION]);
  wire reg_act   = chg_q & (vreg_hit | ireg_hit);
  wire regto_trip = reg_act & (regcnt_q == CNT_W'(REG_TIMEOUT_CYC - 1));
  wire fault_any = die_trip | ts_trip | cfly_trip | conv_trip | vdr_trip | regto_trip;

  // Alarms, never fed into fault_any
  wire [6:0] alm;
  assign alm[0] = either & chen_q[CH_VBAT] & (ch[CH_VBAT] > thr_q[T_VBAT_ALM]);
  assign alm[1] = chg_q & chen_q[CH_IBAT] & (ch[CH_IBAT] > thr_q[T_IBAT_OCA]);
  assign alm[2] = chg_q & chen_q[CH_IBAT] & (ch[CH_IBAT] < thr_q[T_IBAT_UCA]);
  assign alm[3] = either & chen_q[CH_VBUS] & (ch[CH_VBUS] > thr_q[T_VBUS_ALM]);
  assign alm[4] = chg_q & chen_q[CH_IBUS] & (ch[CH_IBUS] > thr_q[T_IBUS_ALM]);
  assign alm[5] = either & chen_q[CH_TDIE] & (ch[CH_TDIE] > thr_q[T_TDIE_ALM]);
  assign alm[6] = either & ts_ok & ts_alm_hit;

  wire [NEV-1:0] ev = {switching_q, alm, regto_trip, vdr_trip, conv_trip,
                       cfly_trip, ts_trip, die_trip};
  wire [NEV-1:0] ev_rise = ev & ~ev_prev_q;

  // Register access, the two-wire side wins a same-cycle write
  wire        wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_q & ~i2c_wr;
  wire        wr_en  = i2c_wr | (wb_hit & wb_we_i);
  wire [5:0]  wr_idx = i2c_wr ? i2c_adr[7:2] : wb_adr_i[7:2];
  wire [3:0]  wr_be  = i2c_wr ? 4'(4'h1 << i2c_adr[1:0]) : wb_sel_i;
  wire [31:0] wr_dat = i2c_wr ? {4{i2c_byte}} : wb_dat_i;

  function automatic logic [31:0] rd_word(input logic [5:0] idx);
    rd_word = 32'h0000_0000;
    if (idx == W_CTRL) rd_word = {30'h0, cnv_q, chg_q};
    else if (idx == W_CHEN) rd_word = {23'h0, chen_q};
    else if (idx == W_STAT) rd_word = {18'h0, ev};
    else if (idx == W_FLAG) rd_word = {18'h0, flag_q};
    else if (idx == W_MASK) rd_word = {18'h0, mask_q};
    else if (idx >= W_THR0 && idx < W_THR0 + 6'(NTHR)) rd_word = {20'h0, thr_q[4'(idx - W_THR0)]};
  endfunction

  wire [31:0] i2c_word = rd_word(i2c_ptr[7:2]);
  wire [7:0]  i2c_rd   = i2c_word[8 * i2c_ptr[1:0] +: 8];

  // Read-to-clear masks per path
  wire wb_flag_rd = wb_hit & ~wb_we_i & (wb_adr_i[7:2] == W_FLAG);
  wire i2c_flag_rd = i2c_take & (i2c_adr[7:2] == W_FLAG);
  wire [NEV-1:0] clr = wb_flag_rd ? {NEV{1'b1}} :
                       i2c_flag_rd && i2c_adr[1:0] == 2'h0 ? NEV'(8'hFF) :
                       i2c_flag_rd && i2c_adr[1:0] == 2'h1 ? {6'h3F, 8'h00} : '0;

  wire int_req = |(ev_rise & ~flag_q & ~mask_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= wb_hit;
      if (wb_hit && !wb_we_i) wb_dat_q <= rd_word(wb_adr_i[7:2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_q <= 1'b0;
      cnv_q <= 1'b0;
      chen_q <= CHEN_RST;
      mask_q <= MASK_RST;
    end else begin
      if (wr_en && wr_idx == W_CTRL && wr_be[0]) begin
        chg_q <= wr_dat[B_CHG];
        cnv_q <= wr_dat[B_CNV];
      end
      if (fault_any) chg_q <= 1'b0;
      if (wr_en && wr_idx == W_CHEN) begin
        if (wr_be[0]) chen_q[7:0] <= wr_dat[7:0];
        if (wr_be[1]) chen_q[8] <= wr_dat[8];
      end
      if (wr_en && wr_idx == W_MASK) begin
        if (wr_be[0]) mask_q[7:0] <= wr_dat[7:0];
        if (wr_be[1]) mask_q[13:8] <= wr_dat[13:8];
      end
    end
  end

  generate
    for (genvar i = 0; i < NTHR; i++) begin : g_thr
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          thr_q[i] <= (i == T_IBAT_UCA) ? THR_UCP_RST : THR_RST;
        end else if (wr_en && wr_idx == W_THR0 + 6'(i)) begin
          if (wr_be[0]) thr_q[i][7:0] <= wr_dat[7:0];
          if (wr_be[1]) thr_q[i][11:8] <= wr_dat[11:8];
        end
      end
    end
  endgenerate

  // Soft start and switching session
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_prev_q <= 1'b0;
      soft_q <= 1'b0;
      switching_q <= 1'b0;
      sscnt_q <= '0;
    end else begin
      chg_prev_q <= chg_q;
      if (!chg_q || cfly_trip) begin
        soft_q <= 1'b0;
        switching_q <= 1'b0;
      end else if (!chg_prev_q) begin
        soft_q <= 1'b1;
        sscnt_q <= '0;
      end else if (soft_q) begin
        if (sscnt_q == CNT_W'(SOFT_START_CYC - 1)) begin
          soft_q <= 1'b0;
          switching_q <= 1'b1;
        end else begin
          sscnt_q <= sscnt_q + 1'b1;
        end
      end
    end
  end

  // Gate throttling and regulation timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= 1'b0;
      regcnt_q <= '0;
    end else begin
      gate_q <= reg_act;
      regcnt_q <= (reg_act && !regto_trip) ? regcnt_q + 1'b1 : '0;
    end
  end

  // Latches: a new occurrence wins over a same-cycle read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev_q <= '0;
      flag_q <= '0;
    end else begin
      ev_prev_q <= ev;
      flag_q <= (flag_q & ~clr) | ev_rise;
    end
  end

  cfa_int_pulse u_pulse (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .req_i    (int_req),
    .int_o    (int_o),
    .int_oe_o (int_oe)
  );

  cfa_i2c_tgt u_tgt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .tgt_addr_i (tgt_q),
    .rd_byte_i  (i2c_rd),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .ptr_o      (i2c_ptr),
    .adr_o      (i2c_adr),
    .rd_take_o  (i2c_take),
    .wr_o       (i2c_wr),
    .wr_byte_o  (i2c_byte)
  );

  assign int_oe_o    = int_oe;
  assign wb_ack_o    = wb_ack_q;
  assign wb_dat_o    = wb_dat_q;
  assign charge_en_o = chg_q;
  assign conv_en_o   = cnv_q;
  assign switching_o = switching_q;
  assign gate_reg_o  = gate_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [PULSE_W-1:0] hi_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) hi_cnt_q <= '0;
    else hi_cnt_q <= int_oe ? hi_cnt_q + 1'b1 : '0;
  end

  sequence s_chg_on;
    chg_q && !chg_prev_q && !cfly_trip;
  endsequence
  sequence s_soft_run;
    soft_q && !switching_q;
  endsequence

  a_die_trip_stop: assert property (die_trip |=> !chg_q)
    else $error("die trip left charging on");
  a_ts_trip_stop: assert property (ts_trip |=> !chg_q ##1 !switching_q)
    else $error("thermistor trip left charging on");
  a_soft_start_run: assert property (s_chg_on |=> s_soft_run)
    else $error("soft start did not begin");
  a_cfly_abort: assert property (cfly_trip |=> !chg_q && !soft_q)
    else $error("short did not abort soft start");
  a_cfly_off_run: assert property (switching_q |-> !cfly_trip)
    else $error("short check active while switching");
  a_conv_oc_stop: assert property (conv_trip |=> !chg_q)
    else $error("converter overcurrent ignored");
  a_dropout_stop: assert property (vdr_trip |=> !chg_q)
    else $error("dropout trip ignored");
  a_gate_follow: assert property (chg_q && (vreg_hit || ireg_hit) |=> gate_reg_o)
    else $error("gate not throttled");
  a_reg_timer: assert property (reg_act && !regto_trip |=> regcnt_q == $past(regcnt_q) + 1'b1)
    else $error("regulation timer stalled");
  a_alarm_no_stop: assert property (chg_q && !fault_any && |alm |=> chg_q)
    else $error("alarm stopped charging");
  a_pulse_width: assert property ($fell(int_oe) |-> hi_cnt_q == PULSE_W'(NOTIFY_CYC))
    else $error("interrupt pulse width wrong");
  a_latch_set: assert property (|ev_rise |=> (flag_q & $past(ev_rise)) == $past(ev_rise))
    else $error("event latch not set");
  a_mask_quiet: assert property (!int_oe && !(|(ev_rise & ~mask_q & ~flag_q)) |=> !int_oe)
    else $error("suppressed event pulsed");
endmodule

// *** verif/cfa_host_model.sv ***
`timescale 1ns/10ps
module cfa_host_model (
  input  wire logic clk_i, // System clock
  input  wire logic sda_i, // Wired data level
  output logic      scl_o, // Serial clock, idles high
  output logic      sda_o  // Data level, high releases
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q(input int n, input logic c, input logic d);
    repeat (n) @(posedge clk_i);
    scl_o <= c;
    sda_o <= d;
  endtask
  // Bit 0 is the acknowledge slot; eight clocks make 320 ns
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      q(2, 1'b0, tx[i]);
      q(2, 1'b1, tx[i]);
      repeat (2) @(posedge clk_i);
      rx[i] = sda_i;
      q(2, 1'b0, tx[i]);
    end
  endtask
  task automatic start();
    q(2, 1'b1, 1'b0);
    q(2, 1'b0, 1'b0);
  endtask
  task automatic stop();
    q(2, 1'b0, 1'b0);
    q(2, 1'b1, 1'b0);
    q(2, 1'b1, 1'b1);
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s %h %h", n, e, g); end end
module testbench;
  import cfa_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, asel = 1'b0, cfly = 1'b0, coc = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wd = 32'h0, rd, dat;
  logic [11:0] ch [9] = '{default: 12'h000};
  logic [8:0]  rx;
  logic        ack, oe, ioe, chg, gate, scl, hsda, sw;
  int          miscompares = 0, compares = 0, n = 0, r;
  always #20 clk_i = ~clk_i;
  cfa_top #(.REG_TIMEOUT_CYC(20), .SOFT_START_CYC(10)) cfa_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(dat), .wb_ack_o(ack), .scl_i(scl), .sda_i(hsda & ~oe), .sda_o(), .sda_oe_o(oe), .int_o(),
    .int_oe_o(ioe), .addr_sel_i(asel), .cfly_short_i(cfly), .conv_oc_i(coc), .vbus_ch_i(ch[0]),
    .ibus_ch_i(ch[1]), .vout_ch_i(ch[2]), .vbat_ch_i(ch[3]), .ibat_ch_i(ch[4]), .tsbus_ch_i(ch[5]),
    .tsbat_ch_i(ch[6]), .tdie_ch_i(ch[7]), .vac_ch_i(ch[8]), .charge_en_o(chg), .conv_en_o(),
    .switching_o(sw), .gate_reg_o(gate));
  cfa_host_model cfa_host_model_inst (.clk_i(clk_i), .sda_i(hsda & ~oe), .scl_o(scl), .sda_o(hsda));
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  function automatic logic [31:0] thr_exp(input int i);
    thr_exp = {20'h0, (i == T_IBAT_UCA) ? THR_UCP_RST : THR_RST};
  endfunction
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    n++;
    if (n == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    r = $urandom(32'he171);
    wt(3);
    rst_i <= 1'b0;
    wt(3);
    for (int i = 0; i < 12; i++) begin
      wb(0, 8'h40 + 8'(4 * i), 0);
      `CHK("thr", thr_exp(i), rd)
    end
    wb(0, 8'h04, 0);
    `CHK("chen", 32'h1FF, rd)
    wb(0, 8'hFC, 0);
    `CHK("unmapped", 32'h0, rd)
    r = $urandom_range(4094, 1);
    wb(1, 8'h10, 32'h2000);
    wb(1, 8'h40, r);
    ch[7] <= 12'(r);
    wb(1, 8'h00, 1);
    wt(15);
    `CHK("chg", 1'b1, chg)
    `CHK("int", 1'b0, ioe)
    ch[7] <= 12'(r + 1);
    wt(3);
    `CHK("chg", 1'b0, chg)
    `CHK("int", 1'b1, ioe)
    wb(0, 8'h0C, 0);
    `CHK("flag", 14'h2001, rd[13:0] & 14'h2001)
    wb(0, 8'h0C, 0);
    `CHK("flag", 1'b0, rd[0])
    ch[7] <= 12'h000;
    wt(NOTIFY_CYC);
    `CHK("int", 1'b0, ioe)
    cfly <= 1'b1;
    wb(1, 8'h00, 1);
    wt(4);
    `CHK("chg", 1'b0, chg)
    cfly <= 1'b0;
    wb(1, 8'h00, 1);
    wt(NOTIFY_CYC);
    cfly <= 1'b1;
    wt(4);
    `CHK("chg", 1'b1, chg)
    `CHK("switching", 1'b1, sw)
    cfly <= 1'b0;
    wb(1, 8'h60, r);
    ch[0] <= 12'(r + 1);
    wt(3);
    `CHK("chg", 1'b1, chg)
    `CHK("int", 1'b1, ioe)
    coc <= 1'b1;
    wt(4);
    `CHK("chg", 1'b0, chg)
    coc <= 1'b0;
    ch[2] <= 12'h100;
    ch[5] <= 12'h081;
    wb(1, 8'h44, 32'h800);
    wb(1, 8'h00, 1);
    wt(4);
    `CHK("chg", 1'b0, chg)
    ch[5] <= 12'h000;
    ch[0] <= 12'h008;
    ch[8] <= 12'h020;
    wb(1, 8'h48, 32'h010);
    wb(1, 8'h00, 1);
    wt(4);
    `CHK("chg", 1'b0, chg)
    ch[8] <= 12'h000;
    wb(1, 8'h4C, r);
    wb(1, 8'h00, 1);
    ch[3] <= 12'(r + 1);
    wt(3);
    `CHK("gate", 1'b1, gate)
    wt(30);
    `CHK("chg", 1'b0, chg)
    cfa_host_model_inst.start();
    cfa_host_model_inst.xfer({TGT_ADDR_B, 2'b01}, rx);
    cfa_host_model_inst.stop();
    `CHK("nack", 1'b1, rx[0])
    cfa_host_model_inst.start();
    cfa_host_model_inst.xfer({TGT_ADDR_A, 2'b01}, rx);
    `CHK("ack", 1'b0, rx[0])
    cfa_host_model_inst.xfer({8'h40, 1'b1}, rx);
    cfa_host_model_inst.xfer({8'(r), 1'b1}, rx);
    cfa_host_model_inst.xfer({8'h0A, 1'b1}, rx);
    cfa_host_model_inst.stop();
    wb(0, 8'h40, 0);
    `CHK("thr", {20'h0, 4'hA, 8'(r)}, rd)
    asel <= 1'b1;
    wt(4);
    cfa_host_model_inst.start();
    cfa_host_model_inst.xfer({TGT_ADDR_B, 2'b01}, rx);
    `CHK("ack", 1'b0, rx[0])
    cfa_host_model_inst.xfer({8'h40, 1'b1}, rx);
    cfa_host_model_inst.stop();
    cfa_host_model_inst.start();
    cfa_host_model_inst.xfer({TGT_ADDR_B, 2'b11}, rx);
    `CHK("ack", 1'b0, rx[0])
    cfa_host_model_inst.xfer(9'h1FE, rx);
    `CHK("rd0", 8'(r), rx[8:1])
    cfa_host_model_inst.xfer(9'h1FF, rx);
    `CHK("rd1", 8'h0A, rx[8:1])
    cfa_host_model_inst.stop();
    finish_test();
  end
endmodule
